/* File: hdl/amp_gain_shutdown_i2c_slave.sv */
// write-only two-wire slave holding the gain and power control byte
//
// Summary of operation
// - slave only; master clocks at most 400kHz
// - sample data on rising serial clock
// - start condition begins address byte reception
// - eight bits then one ack clock
// - answer only to address 1110110
// - writes only; reads never acknowledged
// - matching address gets ack low
// - data byte acked, then loaded
// - gain bits 7..3, zero, enable a, b
// - codes map to -70..+24 dB table
// - both enables low means full shutdown
// - shutdown keeps stored control byte
// - reset clears byte: -70dB, shutdown
// - bus ignored while reset held low
// - after reset stay shut until write
`timescale 1ns/1ns
`include "amp_ctrl_map.svh"
module amp_gain_shutdown_i2c_slave
  import amp_ctrl_pkg::*;
(
  // core clock and reset pin
  input  wire logic       core_clk,
  input  wire logic       nrst,
  // serial bus: clock arrives as the link clock
  input  wire logic       scl_clk,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  // control towards the analog side
  output logic [4:0]      gain_code,
  output gain_db_t        gain_db,
  output logic            amp_en_a,
  output logic            amp_en_b,
  output logic            amp_on,
  output logic            pump_on,
  // bus status
  output logic            frame_busy
);

  // synchronised pins and their previous values
  bus_pins_s    pins_q;
  bus_pins_s    pins_d_r;
  // framing
  frame_state_e state_r;
  frame_state_e state_nxt;
  logic         start_det;   // data falls while clock high
  logic         stop_det;    // data rises while clock high
  logic         link_clr_r;  // holds the link side idle
  // data crossing from the link side
  logic [7:0]   data_hold;   // stable long before the toggle lands
  logic         data_tgl;
  logic         tgl_q;
  logic         tgl_d_r;
  logic         load_pls;    // one core cycle per accepted byte
  // register and decoded outputs
  ctrl_reg_s    ctrl_r;
  gain_db_t     gain_db_r;
  logic         sda_low;

  // no clock output exists; the serial clock is input only

  // clock and data pins through three flops; idle bus reads high
  pin_sync #(
    .W       (2),
    .RST_VAL (2'b11)
  ) u_pin_sync (
    .clk     (core_clk),
    .rst_n   (nrst),
    .d_async ({scl_clk, sda_in}),
    .q       (pins_q)
  );

  // byte toggle from the link domain, same filter
  pin_sync #(
    .W       (1),
    .RST_VAL (1'b0)
  ) u_tgl_sync (
    .clk     (core_clk),
    .rst_n   (nrst),
    .d_async (data_tgl),
    .q       (tgl_q)
  );

  // link-clock side: shifting, matching, acknowledge
  link_rx u_link_rx (
    .scl_clk     (scl_clk),
    .nrst        (nrst),
    .clr         (link_clr_r),
    .sda_in      (sda_in),
    .sda_low_r   (sda_low),
    .data_hold_r (data_hold),
    .data_tgl_r  (data_tgl)
  );

  // open drain: the output level is always low
  assign sda_out = 1'b0;
  assign sda_oe  = sda_low;

  // previous pin values for condition detection
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pins_d_r <= 2'b11;
    end else begin
      pins_d_r <= pins_q;
    end
  end

  // start: data falls with clock high
  assign start_det = pins_q.scl && pins_d_r.scl && pins_d_r.sda && !pins_q.sda;
  // stop: data rises with clock high
  assign stop_det  = pins_q.scl && pins_d_r.scl && !pins_d_r.sda && pins_q.sda;

  // framing: arm on start, run once clock has gone low, idle on stop
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      // bus free, link held clear
      ST_IDLE: begin
        if (start_det) begin
          state_nxt = ST_ARM;
        end
      end
      // start seen; release the link only while the clock is low
      ST_ARM: begin
        if (stop_det) begin
          state_nxt = ST_IDLE;
        end else if (!pins_q.scl) begin
          state_nxt = ST_FRAME;
        end
      end
      // bits flowing in the link domain
      ST_FRAME: begin
        if (stop_det) begin
          state_nxt = ST_IDLE;
        end else if (start_det) begin
          state_nxt = ST_ARM;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // reset keeps framing idle, so the bus is ignored
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // link clear is registered: it drives an asynchronous clear, so no glitches
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      link_clr_r <= 1'b1;
    end else begin
      // partial byte dropped by clearing the link
      link_clr_r <= (state_nxt != ST_FRAME);
    end
  end

  // edge of the filtered toggle marks a fresh byte
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      tgl_d_r <= 1'b0;
    end else begin
      tgl_d_r <= tgl_q;
    end
  end

  assign load_pls = tgl_q ^ tgl_d_r;

  // control byte: only reset or an acknowledged write changes it
  // held until written
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      // cleared to lowest gain and shutdown
      ctrl_r <= `AMP_CTRL_RST;
    end else if (load_pls) begin
      // fields placed, reserved bit forced to zero
      ctrl_r.gain_code <= data_hold[`AMP_GAIN_MSB:`AMP_GAIN_LSB];
      ctrl_r.rsvd      <= `AMP_RSVD_VAL;
      ctrl_r.amp_en_a  <= data_hold[`AMP_EN_A_BIT];
      ctrl_r.amp_en_b  <= data_hold[`AMP_EN_B_BIT];
    end
  end

  // gain table: irregular low half, then 2 dB steps, then 1 dB steps
  function automatic gain_db_t gain_of(input logic [4:0] code);
    gain_db_t g;
    g = `AMP_GAIN_MIN_DB;
    case (code)
      5'h00: g = `AMP_GAIN_MIN_DB;
      5'h01: g = -8'sh38;
      5'h02: g = -8'sh2e;
      5'h03: g = -8'sh26;
      5'h04: g = -8'sh20;
      5'h05: g = -8'sh1c;
      5'h06: g = -8'sh18;
      5'h07: g = -8'sh15;
      5'h08: g = -8'sh12;
      5'h09: g = -8'sh0f;
      5'h0a: g = -8'sh0c;
      5'h0b: g = -8'sh0a;
      5'h0c: g = -8'sh08;
      5'h0d: g = -8'sh06;
      5'h0e: g = -8'sh04;
      5'h0f: g = -8'sh02;
      default: begin
        if (code <= 5'h19) begin
          // 0 to 18 dB in steps of two
          g = gain_db_t'({3'h0, code - 5'h10} << 1);
        end else begin
          // 19 to 24 dB in steps of one
          g = gain_db_t'({3'h0, code - 5'h07});
        end
      end
    endcase
    return g;
  endfunction

  // registered gain, one cycle behind the code
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      gain_db_r <= `AMP_GAIN_MIN_DB;
    end else begin
      gain_db_r <= gain_of(ctrl_r.gain_code);
    end
  end

  // outputs straight from the register
  assign gain_code  = ctrl_r.gain_code;
  assign gain_db    = gain_db_r;
  assign amp_en_a   = ctrl_r.amp_en_a;
  assign amp_en_b   = ctrl_r.amp_en_b;
  // both low: amplifier and pump off
  // a single enable still runs the device
  assign amp_on     = ctrl_r.amp_en_a | ctrl_r.amp_en_b;
  assign pump_on    = ctrl_r.amp_en_a | ctrl_r.amp_en_b;
  assign frame_busy = (state_r != ST_IDLE);

  // ---------------------------------------------------------------
  // checks on the core domain
  // ---------------------------------------------------------------

  // first cycle after reset release
  logic rst_seen_r;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rst_seen_r <= 1'b0;
    end else begin
      rst_seen_r <= 1'b1;
    end
  end

  // a start condition on the filtered pins
  sequence s_start;
    pins_d_r.sda && !pins_q.sda && pins_q.scl && pins_d_r.scl;
  endsequence

  // clock low after the start lets the link run
  sequence s_clock_low;
    !pins_q.scl;
  endsequence

  // a fresh byte arriving
  sequence s_byte_in;
    load_pls;
  endsequence

  // register comes out of reset cleared and shut
  a_reset_clears: assert property (
    @(posedge core_clk) disable iff (!nrst)
    !rst_seen_r |-> (ctrl_r == `AMP_CTRL_RST) && !amp_on && !pump_on)
    else $error("control byte not cleared by reset");

  // with no byte for three cycles after reset release, the device is still shut at lowest gain
  a_shut_until_write: assert property (
    @(posedge core_clk) disable iff (!nrst)
    (!rst_seen_r ##1 !load_pls [*3]) |-> !amp_on && gain_db_r == `AMP_GAIN_MIN_DB)
    else $error("device woke without a write");

  // a start always clears the link side, then releases it on clock low
  a_start_restarts: assert property (
    @(posedge core_clk) disable iff (!nrst)
    (s_start ##1 !stop_det) |-> link_clr_r ##0 (state_r == ST_ARM))
    else $error("start did not restart the link");

  // the link runs only after the clock has gone low inside a frame
  a_arm_then_run: assert property (
    @(posedge core_clk) disable iff (!nrst)
    (state_r == ST_ARM && !stop_det) ##0 s_clock_low |=> !link_clr_r)
    else $error("link not released after start");

  // an accepted byte lands in the register the next cycle
  a_write_loads: assert property (
    @(posedge core_clk) disable iff (!nrst)
    s_byte_in |=> ctrl_r.gain_code == $past(data_hold[`AMP_GAIN_MSB:`AMP_GAIN_LSB])
      && ctrl_r.amp_en_a == $past(data_hold[`AMP_EN_A_BIT])
      && ctrl_r.amp_en_b == $past(data_hold[`AMP_EN_B_BIT]))
    else $error("written byte not loaded");

  // nothing but a write changes the register, shutdown included
  a_reg_holds: assert property (
    @(posedge core_clk) disable iff (!nrst)
    !load_pls |=> $stable(ctrl_r))
    else $error("control byte changed without a write");

  // reserved bit reads back zero whatever was written
  a_rsvd_zero: assert property (
    @(posedge core_clk) disable iff (!nrst)
    ctrl_r.rsvd == `AMP_RSVD_VAL)
    else $error("reserved bit stored as one");

  // power follows the enables: both low is shutdown, any high is on
  a_power_mode: assert property (
    @(posedge core_clk) disable iff (!nrst)
    (amp_on == (ctrl_r.amp_en_a || ctrl_r.amp_en_b)) && (pump_on == amp_on))
    else $error("power state does not follow enables");

  // end points of the gain table after a steady code
  a_gain_ends: assert property (
    @(posedge core_clk) disable iff (!nrst)
    $stable(ctrl_r.gain_code) |->
      (ctrl_r.gain_code != 5'h00 || gain_db_r == `AMP_GAIN_MIN_DB)
      && (ctrl_r.gain_code != 5'h1f || gain_db_r == `AMP_GAIN_MAX_DB))
    else $error("gain decode wrong at table ends");

  // a held clear keeps the data line released
  a_clear_releases: assert property (
    @(posedge core_clk) disable iff (!nrst)
    link_clr_r [*2] |-> !sda_oe)
    else $error("data line driven while link is cleared");

  // a stop returns the bus to idle within one cycle
  a_stop_idles: assert property (
    @(posedge core_clk) disable iff (!nrst)
    stop_det |=> (state_r == ST_IDLE) && link_clr_r)
    else $error("stop did not end the frame");

endmodule // amp_gain_shutdown_i2c_slave

/* File: hdl/link_rx.sv */
// serial-clock domain receiver: bit shifting, address match and acknowledge drive
`timescale 1ns/1ns
`include "amp_ctrl_map.svh"
module link_rx
  import amp_ctrl_pkg::*;
(
  // link clock and resets
  input  wire logic       scl_clk,
  input  wire logic       nrst,
  input  wire logic       clr,        // high between frames, held by the core
  // serial data
  input  wire logic       sda_in,
  output logic            sda_low_r,  // pull the data line low
  // received byte towards the core
  output logic [7:0]      data_hold_r,
  output logic            data_tgl_r
);

  logic [7:0]  shreg_r;   // incoming bits
  logic [3:0]  bit_cnt_r; // 0..7 data bits, 8 = ack clock
  link_phase_e phase_r;
  logic        addr_ok;
  logic        ack_ok;

  // address and write direction both match
  assign addr_ok = (shreg_r == {`AMP_DEV_ADDR, `AMP_DIR_WRITE});
  // a read address is never acknowledged
  assign ack_ok  = ((phase_r == PH_ADDR) && addr_ok) || (phase_r == PH_DATA);

  // bits taken on the rising serial clock
  always_ff @(posedge scl_clk or posedge clr) begin
    if (clr) begin
      shreg_r   <= 8'h00;
      bit_cnt_r <= 4'h0;
      phase_r   <= PH_ADDR;
    end else if (bit_cnt_r != `AMP_ACK_SLOT) begin
      shreg_r   <= {shreg_r[6:0], sda_in};
      bit_cnt_r <= bit_cnt_r + 4'h1;
    end else begin
      bit_cnt_r <= 4'h0;
      if (phase_r == PH_ADDR && addr_ok) begin
        phase_r <= PH_DATA;
      end else begin
        phase_r <= PH_IGNORE;
      end
    end
  end

  // latch the acknowledged data byte; kept across frames
  always_ff @(posedge scl_clk or negedge nrst) begin
    if (!nrst) begin
      data_hold_r <= `AMP_CTRL_RST;
      data_tgl_r  <= 1'b0;
    end else if (!clr && bit_cnt_r == `AMP_ACK_SLOT && phase_r == PH_DATA) begin
      data_hold_r <= shreg_r;
      data_tgl_r  <= ~data_tgl_r;
    end
  end

  // drive low on the falling edge before the ack clock
  always_ff @(negedge scl_clk or posedge clr) begin
    if (clr) begin
      sda_low_r <= 1'b0;
    end else begin
      // released outside the ack window or without a match
      sda_low_r <= (bit_cnt_r == `AMP_ACK_SLOT) && ack_ok;
    end
  end

  // acknowledge lasts exactly one serial clock
  a_ack_one_clock: assert property (
    @(negedge scl_clk) disable iff (clr) sda_low_r |=> !sda_low_r)
    else $error("acknowledge held past one clock");

  // read requests never see an acknowledge
  a_read_no_ack: assert property (
    @(posedge scl_clk) disable iff (clr)
    (phase_r == PH_ADDR && bit_cnt_r == `AMP_ACK_SLOT && shreg_r[0]) |-> !sda_low_r)
    else $error("read direction acknowledged");

endmodule // link_rx

/* File: hdl/pin_sync.sv */
// three-flop synchroniser that passes a change once the last two flops agree
`timescale 1ns/1ns
module pin_sync #(
  parameter int         W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // asynchronous input and filtered output
  input  wire logic [W-1:0] d_async,
  output logic      [W-1:0] q
);

  logic [W-1:0] s1_r;  // metastable stage, read by s2 only
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  // three stages in a row
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= RST_VAL;
      s2_r <= RST_VAL;
      s3_r <= RST_VAL;
    end else begin
      s1_r <= d_async;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // per bit: accept only where stages two and three agree
  for (genvar i = 0; i < W; i++) begin : g_agree
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        q[i] <= RST_VAL[i];
      end else if (s2_r[i] == s3_r[i]) begin
        q[i] <= s3_r[i];
      end
    end
  end

endmodule // pin_sync

/* File: inc/amp_ctrl_map.svh */
// offsets, field positions, reset values and timing counts for the amplifier control slave
`ifndef AMP_CTRL_MAP_SVH
`define AMP_CTRL_MAP_SVH

// seven-bit bus address and the write direction value
`define AMP_DEV_ADDR      7'h76
`define AMP_DIR_WRITE     1'b0
// bits in one byte on the wire, and the index of the acknowledge clock
`define AMP_BYTE_BITS     4'h8
`define AMP_ACK_SLOT      4'h8
// control byte field positions
`define AMP_GAIN_MSB      7
`define AMP_GAIN_LSB      3
`define AMP_RSVD_BIT      2
`define AMP_EN_A_BIT      1
`define AMP_EN_B_BIT      0
// control byte value after reset: lowest gain, both enables off
`define AMP_CTRL_RST      8'h00
`define AMP_RSVD_VAL      1'b0
// fastest serial clock the master may use, and the core clock
`define AMP_SCL_MAX_KHZ   400
`define AMP_CORE_MHZ      250
// shortest serial clock period in core cycles (least time, rounded up)
`define AMP_SCL_MIN_CYC   ((`AMP_CORE_MHZ * 1000 + `AMP_SCL_MAX_KHZ - 1) / `AMP_SCL_MAX_KHZ)
// gains at the two ends of the code range, in dB
`define AMP_GAIN_MIN_DB   (-8'sh46)
`define AMP_GAIN_MAX_DB   8'sh18

`endif

/* File: inc/amp_ctrl_pkg.sv */
// types shared by the amplifier control slave
package amp_ctrl_pkg;

  // control byte as it sits in the register
  typedef struct packed {
    logic [4:0] gain_code;   // volume code, msb first
    logic       rsvd;        // always stored as zero
    logic       amp_en_a;    // enable a
    logic       amp_en_b;    // enable b
  } ctrl_reg_s;

  // the two bus pins as seen by the core
  typedef struct packed {
    logic scl;
    logic sda;
  } bus_pins_s;

  // gain in dB, two's complement
  typedef logic signed [7:0] gain_db_t;

  // which byte the link side expects next
  typedef enum logic [1:0] {PH_ADDR, PH_DATA, PH_IGNORE} link_phase_e;

  // core side framing state
  typedef enum logic [1:0] {ST_IDLE, ST_ARM, ST_FRAME} frame_state_e;

endpackage

/* File: testbench/amp_gain_shutdown_i2c_slave_tb_top.sv */
// self-checking bench for the gain and power control slave
`timescale 1ns/1ns
module amp_gain_shutdown_i2c_slave_tb_top
  import amp_ctrl_pkg::*;
;
  logic     core_clk = 1'b0;  // 250 MHz core clock
  logic     nrst = 1'b0;      // reset pin, low at start
  logic     scl_clk;          // link clock from the master
  logic     m_low;            // master pulls data low
  logic     sda_in;           // resolved data line
  logic     sda_out;
  logic     sda_oe;
  logic [4:0] gain_code;
  gain_db_t gain_db;
  logic     amp_en_a;
  logic     amp_en_b;
  logic     amp_on;
  logic     pump_on;
  logic     frame_busy;
  int       err_count = 0;    // mismatches
  int       checked = 0;      // comparisons made

  // open drain: pull-up unless someone pulls low
  assign sda_in = ~(m_low | (sda_oe & ~sda_out));

  // core clock
  initial begin
    forever #2 core_clk = ~core_clk;
  end

  amp_gain_shutdown_i2c_slave amp_gain_shutdown_i2c_slave_i (
    .core_clk(core_clk), .nrst(nrst), .scl_clk(scl_clk), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .gain_code(gain_code), .gain_db(gain_db),
    .amp_en_a(amp_en_a), .amp_en_b(amp_en_b), .amp_on(amp_on), .pump_on(pump_on),
    .frame_busy(frame_busy));

  bus_master_model bus_master_model_i (.scl(scl_clk), .sda_low(m_low), .sda_line(sda_in));

  // one comparison, four-state exact
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // expected gain in dB for a code, worked out from the table
  function automatic logic [7:0] exp_db(input int c);
    int lo[16] = '{-70, -56, -46, -38, -32, -28, -24, -21, -18, -15, -12, -10, -8, -6,
                   -4, -2};
    if (c < 16) return 8'(lo[c]);
    if (c < 26) return 8'((c - 16) * 2);
    return 8'(c - 7);
  endfunction

  // all control outputs against the byte that should be stored
  task automatic check_ctrl(input logic [7:0] b);
    check({3'h0, gain_code}, {3'h0, b[7:3]}, "gain code");
    check(gain_db, exp_db(int'(b[7:3])), "gain db");
    check({7'h0, amp_en_a}, {7'h0, b[1]}, "enable a");
    check({7'h0, amp_en_b}, {7'h0, b[0]}, "enable b");
    check({7'h0, amp_on}, {7'h0, |b[1:0]}, "amp on");
    check({7'h0, pump_on}, {7'h0, |b[1:0]}, "pump on");
  endtask

  // whole write frame, then time for the byte to cross into the core
  task automatic write_frame(input logic [7:0] adr, input logic [7:0] d, output logic a1,
                             output logic a2);
    bus_master_model_i.start_cond();
    bus_master_model_i.send_bits(adr, 8, a1);
    bus_master_model_i.send_bits(d, 8, a2);
    bus_master_model_i.stop_cond();
    repeat (10) @(negedge core_clk);
  endtask

  // state straight after reset release
  task automatic t_reset_state();
    check_ctrl(8'h00);
    check({7'h0, sda_oe}, 8'h00, "oe idle");
    check({7'h0, frame_busy}, 8'h00, "busy idle");
  endtask

  // every volume code, both acks given
  task automatic t_gain_table();
    logic a1;
    logic a2;
    for (int c = 0; c < 32; c++) begin
      write_frame(8'hec, {5'(c), 3'b011}, a1, a2);
      check({7'h0, a1}, 8'h01, "addr ack");
      check({7'h0, a2}, 8'h01, "data ack");
      check_ctrl({5'(c), 3'b011});
    end
  endtask

  // all enable pairs; shutdown keeps the volume
  task automatic t_enable_modes();
    logic a1;
    logic a2;
    for (int e = 0; e < 4; e++) begin
      write_frame(8'hec, {5'h15, 1'b0, 2'(e)}, a1, a2);
      check_ctrl({5'h15, 1'b0, 2'(e)});
    end
    write_frame(8'hec, 8'ha3, a1, a2);
    check({6'h0, a1, a2}, 8'h03, "acks last mode");
    check_ctrl(8'ha3);
  endtask

  // read direction and foreign addresses are left alone
  task automatic t_refused();
    logic [7:0] adr[3] = '{8'hed, 8'hee, 8'h6c};
    logic       a1;
    logic       a2;
    foreach (adr[i]) begin
      write_frame(adr[i], 8'h5c, a1, a2);
      check({6'h0, a1, a2}, 8'h00, "no ack");
      check_ctrl(8'ha3);
    end
  endtask

  // start inside the data byte drops the partial byte
  task automatic t_restart();
    logic a1;
    bus_master_model_i.start_cond();
    check({7'h0, frame_busy}, 8'h01, "busy in frame");
    bus_master_model_i.send_bits(8'hec, 8, a1);
    check({7'h0, a1}, 8'h01, "ack before restart");
    bus_master_model_i.send_bits(8'h18, 4, a1);
    bus_master_model_i.start_cond();
    bus_master_model_i.send_bits(8'hec, 8, a1);
    check({7'h0, a1}, 8'h01, "ack after restart");
    bus_master_model_i.stop_cond();
    repeat (10) @(negedge core_clk);
    check({7'h0, frame_busy}, 8'h00, "busy after stop");
    check_ctrl(8'ha3);
  endtask

  // reset clears, bus ignored while held, shut until written
  task automatic t_reset_hold();
    logic a1;
    logic a2;
    @(negedge core_clk);
    nrst = 1'b0;
    repeat (2) @(negedge core_clk);
    check_ctrl(8'h00);
    write_frame(8'hec, 8'hff, a1, a2);
    check({6'h0, a1, a2}, 8'h00, "ack in reset");
    check_ctrl(8'h00);
    nrst = 1'b1;
    repeat (6) @(negedge core_clk);
    check_ctrl(8'h00);
    write_frame(8'hec, 8'h83, a1, a2);
    check({6'h0, a1, a2}, 8'h03, "acks after reset");
    check_ctrl(8'h83);
    check({7'h0, sda_out}, 8'h00, "drives low only");
  endtask

  // counts, verdict and end of run
  task automatic give_verdict();
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // main sequence; odd delay keeps the link clock off the core phase
  initial begin
    repeat (2) @(negedge core_clk);
    nrst = 1'b1;
    repeat (6) @(negedge core_clk);
    #7;
    t_reset_state();
    t_gain_table();
    t_enable_modes();
    t_refused();
    t_restart();
    t_reset_hold();
    give_verdict();
  end

  // watchdog: about three times the expected run
  initial begin
    #200000;
    err_count++;
    give_verdict();
  end
endmodule // amp_gain_shutdown_i2c_slave_tb_top

/* File: testbench/bus_master_model.sv */
// two-wire bus master model: makes the serial clock and pulls the data line
`timescale 1ns/1ns
module bus_master_model (
  // bus lines
  output logic      scl,       // serial clock, stands high outside frames
  output logic      sda_low,   // master pulls data low
  input  wire logic sda_line   // resolved data line, pulled up
);
  // half and quarter of the 48 ns link clock period
  localparam int HALF = 24;
  localparam int QTR  = 12;

  // idle bus: clock high, data released
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  // one clock pulse; data only moves while the clock is low
  task automatic clk_pulse();
    #QTR;
    scl = 1'b1;
    #HALF;
    scl = 1'b0;
    #QTR;
  endtask

  // start: data falls while clock high
  task automatic start_cond();
    sda_low = 1'b0;
    #QTR;
    scl = 1'b1;
    #100;
    sda_low = 1'b1;
    #100;
    scl = 1'b0;
    // clock kept low a while so the device frees its link logic
    #60;
  endtask

  // msb first, then the ack clock after a whole byte
  task automatic send_bits(input logic [7:0] b, input int n, output logic ack);
    for (int i = 7; i > 7 - n; i--) begin
      sda_low = ~b[i];
      clk_pulse();
    end
    ack = 1'b0;
    if (n == 8) begin
      // data released for the ack clock
      sda_low = 1'b0;
      #QTR;
      scl = 1'b1;
      // ack taken at the rising edge of the ack clock
      ack = (sda_line === 1'b0);
      #HALF;
      scl = 1'b0;
      #QTR;
    end
  endtask

  // stop: data rises while clock high
  task automatic stop_cond();
    sda_low = 1'b1;
    #QTR;
    scl = 1'b1;
    #100;
    sda_low = 1'b0;
    #200;
  endtask
endmodule // bus_master_model
